// File: embedded_flash_controller.sv
// Purpose: Embedded flash controller: wait-stated reads with prefetch, page
//          latch buffer, keyed program/lock/erase sequencer, AXI4-Lite regs
// Assumes: Flash plane modelled as an array; one request at a time on fbus
// Notes:   Sequencer timings scale with cycles_per_microsecond
//
// What this block does
// - Two 32-bit prefetch buffers serve code fetches, never data reads
// - Wait states range 0 to 3; zero gives single-cycle reads
// - One wait state: sequential run costs an extra cycle only first
// - Two or three wait states: sequential accesses alternate slow and fast
// - Byte, halfword and word reads are all accepted
// - Reads decode only address bits spanning the flash size
// - Writes land in page latch indexed by low eight address bits
// - Latch writes take one more wait state, except at setting three
// - Command field decodes page write, lock set, write-lock, clear, erase
// - Every command must carry the fixed key in its top byte
// - Bad key or code sets command error, array untouched
// - Writing or erasing a locked region sets violation, array untouched
// - Software sets cycles per microsecond; timings derive from it
// - Page write erases first when skip-page-erase is zero, then programs
// - Programming end sets program_done and its enabled interrupt
// - Status read clears program_done and drops its interrupt
// - Skip-page-erase set programs without erase, allowing partial steps
// - One lock bit per region, shown in top status bits
// - Lock clear reads status 0, lock set reads 1, any page selects
// - Lock operation end sets lock_op_done; no flash access meanwhile
// - Write-then-lock starts the region lock after programming completes
// - Full erase is cancelled with violation if any region locked
// - Code zero does nothing; unlisted codes set command error
// - Mode register holds one interrupt enable per status flag
`timescale 1ns/100ps
`default_nettype none
module embedded_flash_controller
  import flash_ctrl_pkg::*;
#(
  parameter int          PAGES         = 1024,
  parameter int          PAGE_BYTES    = 256,
  parameter int          LOCK_REGIONS  = 16,
  parameter int unsigned PAGE_ERASE_US = 2000,
  parameter int unsigned PAGE_PROG_US  = 2000,
  parameter int unsigned LOCK_US       = 1000,
  parameter int unsigned FULL_ERASE_US = 10000,
  parameter logic [7:0]  CMD_KEY       = 8'ha5,   // Arbitrary value
  parameter logic [LOCK_REGIONS-1:0] LOCK_RESET = '0
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // AXI4-Lite register slave
  input  wire logic [REG_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [REG_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Internal system bus to the flash region
  input  wire fbus_req_t         fbus,
  output logic                   fbus_ready,
  output logic [31:0]            fbus_rdata,
  // Interrupt
  output logic                   irq
);

  localparam int WPP   = PAGE_BYTES / 4;
  localparam int WORDS = PAGES * WPP;
  localparam int FWAW  = $clog2(WORDS);
  localparam int PAW   = $clog2(PAGES);
  localparam int LAW   = $clog2(WPP);
  localparam int PPR   = PAGES / LOCK_REGIONS;
  localparam int RAW   = $clog2(LOCK_REGIONS);

  function automatic logic [RAW-1:0] region_of(input logic [PAW-1:0] page);
    return RAW'(page / PAW'(PPR));
  endfunction

  function automatic logic [31:0] op_cycles(input logic [7:0] cpm, input int unsigned us);
    logic [31:0] prod;
    prod = 32'(cpm) * 32'(us);
    return (prod == 32'h0) ? 32'h0 : prod - 32'h1;
  endfunction

  function automatic logic [31:0] mode_word(input mode_t m);
    return (32'(m.cycles_per_microsecond) << CYCLES_PER_MICROSECOND_LSB) | (32'(m.wait_state_count) << FWS_LSB)
         | (32'(m.skip_page_erase) << SKIP_PAGE_ERASE_BIT) | (32'(m.irq_en) << IRQ_EN_LSB);
  endfunction

  // Storage
  logic [31:0]             flash_mem [WORDS];
  logic [31:0]             latch_mem [WPP];
  mode_t                   mode;
  flags_t                  flags;
  logic [LOCK_REGIONS-1:0] lock_bits;
  seq_state_t              st;

  // AXI write side
  logic              aw_held;
  logic              w_held;
  logic [REG_AW-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;

  wire         wr_go   = aw_held && w_held && !s_axi_bvalid;

  assign s_axi_bresp = RESP_OKAY;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= 32'h0;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  wire         mode_wr = wr_go && (wr_addr == MODE_OFS);
  wire         cmd_wr  = wr_go && (wr_addr == CMD_OFS) && (wr_strb == 4'hf);
  wire  [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire  [31:0] mode_merge = (mode_word(mode) & ~strb_mask) | (wr_data & strb_mask);

  // AXI read side; reading status clears its flags
  wire         ar_hs   = s_axi_arvalid && s_axi_arready;
  wire         stat_rd = ar_hs && (s_axi_araddr == STAT_OFS);
  wire  [31:0] stat_word = 32'(flags) | (32'(lock_bits) << (32 - LOCK_REGIONS));
  wire         rd_known = (s_axi_araddr == MODE_OFS) || (s_axi_araddr == CMD_OFS)
                        || (s_axi_araddr == STAT_OFS);
  wire  [31:0] rd_value = (s_axi_araddr == MODE_OFS) ? mode_word(mode)
                        : (s_axi_araddr == STAT_OFS) ? stat_word : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_value;
      s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Command decode
  wire          [7:0] cmd_key  = wr_data[KEY_LSB +: 8];
  wire command_code_t cmd_code = command_code_t'(wr_data[CODE_LSB +: 4]);
  wire        [PAW-1:0] cmd_page = wr_data[PAGE_LSB +: PAW];
  wire key_ok     = (cmd_key == CMD_KEY);
  wire code_known = (cmd_code == CMD_PAGE_WRITE) || (cmd_code == CMD_LOCK_BIT_SET)
                 || (cmd_code == CMD_WRITE_THEN_LOCK) || (cmd_code == CMD_LOCK_BIT_CLEAR)
                 || (cmd_code == CMD_FULL_ERASE);
  wire is_page_wr = (cmd_code == CMD_PAGE_WRITE) || (cmd_code == CMD_WRITE_THEN_LOCK);
  // A command arriving mid-operation is refused as an error rather than queued
  wire cmd_bad    = cmd_wr && (!key_ok || (cmd_code != CMD_NONE &&
                    (!code_known || st != ST_IDLE)));
  wire cmd_go     = cmd_wr && key_ok && code_known && (st == ST_IDLE);
  wire lock_viol  = cmd_go && ((is_page_wr && lock_bits[region_of(cmd_page)])
                 || (cmd_code == CMD_FULL_ERASE && |lock_bits));
  wire cmd_start  = cmd_go && !lock_viol;

  // Sequencer
  logic [PAW-1:0] op_page;
  logic           op_wpl;
  logic           op_set;
  logic [FWAW:0]  word_cnt;
  logic [31:0]    timer;

  wire [FWAW:0] word_lim   = (st == ST_FULL_ERASE) ? (FWAW+1)'(WORDS) : (FWAW+1)'(WPP);
  wire          words_done = (st == ST_LOCK_OP) || (word_cnt == word_lim);
  wire          phase_done = (st != ST_IDLE) && (timer == 32'h0) && words_done;
  wire          arr_we     = (st != ST_IDLE) && (st != ST_LOCK_OP) && !words_done;
  wire [FWAW-1:0] arr_idx  = (st == ST_FULL_ERASE) ? word_cnt[FWAW-1:0]
                           : {op_page, word_cnt[LAW-1:0]};
  wire [31:0]   arr_wdata  = (st == ST_PAGE_PROG)
                           ? (flash_mem[arr_idx] & latch_mem[word_cnt[LAW-1:0]])
                           : ERASED_WORD;
  wire [7:0]    cpm        = mode.cycles_per_microsecond;

  seq_state_t  next_st;
  logic [31:0] next_timer;
  always_comb begin
    next_st    = st;
    next_timer = (timer == 32'h0) ? timer : timer - 32'h1;
    case (st)
      ST_IDLE: begin
        if (cmd_start) begin
          if (cmd_code == CMD_FULL_ERASE) begin
            next_st    = ST_FULL_ERASE;
            next_timer = op_cycles(cpm, FULL_ERASE_US);
          end else if (!is_page_wr) begin
            next_st    = ST_LOCK_OP;
            next_timer = op_cycles(cpm, LOCK_US);
          end else if (mode.skip_page_erase) begin
            next_st    = ST_PAGE_PROG;
            next_timer = op_cycles(cpm, PAGE_PROG_US);
          end else begin
            next_st    = ST_PAGE_ERASE;
            next_timer = op_cycles(cpm, PAGE_ERASE_US);
          end
        end
      end
      ST_PAGE_ERASE: begin
        if (phase_done) begin
          next_st    = ST_PAGE_PROG;
          next_timer = op_cycles(cpm, PAGE_PROG_US);
        end
      end
      ST_PAGE_PROG: begin
        if (phase_done && op_wpl) begin
          next_st    = ST_LOCK_OP;
          next_timer = op_cycles(cpm, LOCK_US);
        end else if (phase_done) begin
          next_st = ST_IDLE;
        end
      end
      ST_LOCK_OP, ST_FULL_ERASE: begin
        if (phase_done) begin
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= ST_IDLE;
      timer    <= 32'h0;
      word_cnt <= '0;
      op_page  <= '0;
      op_wpl   <= 1'b0;
      op_set   <= 1'b0;
    end else begin
      st       <= next_st;
      timer    <= next_timer;
      word_cnt <= (next_st != st) ? '0 : (arr_we ? word_cnt + 1'b1 : word_cnt);
      if (cmd_start) begin
        op_page <= cmd_page;
        op_wpl  <= (cmd_code == CMD_WRITE_THEN_LOCK);
        op_set  <= (cmd_code != CMD_LOCK_BIT_CLEAR);   // Write-then-lock sets
      end
    end
  end

  wire wr_accept;

  // Flash plane and latch contents carry no reset, like the real cells
  always_ff @(posedge clk) begin
    if (arr_we) begin
      flash_mem[arr_idx] <= arr_wdata;
    end
    if (wr_accept) begin
      latch_mem[fbus.addr[2 +: LAW]] <= fbus.wdata;
    end
  end

  // Lock bits, mode register, flags and interrupt
  flags_t next_flags;
  wire flags_t flag_set;
  mode_t  next_mode;
  assign flag_set.program_done            = phase_done && (st == ST_PAGE_PROG
                                          || st == ST_FULL_ERASE);
  assign flag_set.lock_op_done            = phase_done && (st == ST_LOCK_OP);
  assign flag_set.region_locked_violation = lock_viol;
  assign flag_set.command_error_flag      = cmd_bad;
  // A flag raised in the cycle of a status read survives it
  assign next_flags = (stat_rd ? flags_t'(4'h0) : flags) | flag_set;
  assign next_mode  = mode_wr ? mode_t'({mode_merge[CYCLES_PER_MICROSECOND_LSB +: 8], mode_merge[FWS_LSB +: 2],
                      mode_merge[SKIP_PAGE_ERASE_BIT], mode_merge[IRQ_EN_LSB +: 4]}) : mode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_bits <= LOCK_RESET;
      mode      <= '0;
      flags     <= '0;
      irq       <= 1'b0;
    end else begin
      if (flag_set.lock_op_done) begin
        lock_bits[region_of(op_page)] <= op_set;
      end
      mode  <= next_mode;
      flags <= next_flags;
      irq   <= |(next_flags & next_mode.irq_en);
    end
  end

  // Read and latch-write path
  logic            fb_busy;
  logic [2:0]      fb_cnt;
  logic [FWAW-1:0] tag0;
  logic [FWAW-1:0] tag1;
  logic [FWAW-1:0] last_word;
  logic [31:0]     buf0;
  logic [31:0]     buf1;
  logic            buf_v;
  logic            last_v;

  wire [1:0]      ws        = mode.wait_state_count;
  wire            accept    = fbus.req && !fb_busy && !fbus_ready && (st == ST_IDLE);
  wire            rd_accept = accept && !fbus.write;
  assign          wr_accept = accept && fbus.write;
  wire [FWAW-1:0] widx      = fbus.addr[2 +: FWAW];
  wire            hit0      = fbus.fetch && buf_v && (tag0 == widx);
  wire            hit1      = fbus.fetch && buf_v && (tag1 == widx);
  wire            seq_run   = fbus.fetch && last_v && (widx == last_word + 1'b1);
  wire [31:0]     word_now  = hit0 ? buf0 : (hit1 ? buf1 : flash_mem[widx]);
  wire [2:0]      rd_lat    = (hit0 || hit1 || (seq_run && ws == 2'h1))
                            ? 3'h1 : 3'(ws) + 3'h1;
  wire [2:0]      wr_lat    = (ws == WS_MAX) ? WR_LAT_MAX : 3'(ws) + 3'h2;
  wire [2:0]      lat       = fbus.write ? wr_lat : rd_lat;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_busy    <= 1'b0;
      fb_cnt     <= 3'h0;
      fbus_ready <= 1'b0;
      fbus_rdata <= 32'h0;
    end else begin
      fbus_ready <= 1'b0;
      if (accept) begin
        fbus_rdata <= fbus.write ? 32'h0 : word_now;
        fbus_ready <= (lat == 3'h1);
        fb_busy    <= (lat != 3'h1);
        fb_cnt     <= lat - 3'h1;
      end else if (fb_busy) begin
        fb_cnt <= fb_cnt - 3'h1;
        if (fb_cnt == 3'h1) begin
          fbus_ready <= 1'b1;
          fb_busy    <= 1'b0;
        end
      end
    end
  end

  // Prefetch pair: a fetch miss loads the word and its successor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_v     <= 1'b0;
      last_v    <= 1'b0;
      tag0      <= '0;
      tag1      <= '0;
      buf0      <= 32'h0;
      buf1      <= 32'h0;
      last_word <= '0;
    end else if (st != ST_IDLE) begin
      buf_v  <= 1'b0;     // Plane is changing, stale copies must go
      last_v <= 1'b0;
    end else if (rd_accept && fbus.fetch) begin
      last_v    <= 1'b1;
      last_word <= widx;
      if (!(hit0 || hit1)) begin
        buf_v <= 1'b1;
        tag0  <= widx;
        buf0  <= flash_mem[widx];
        tag1  <= widx + 1'b1;
        buf1  <= flash_mem[widx + 1'b1];
      end
    end
  end

  // Checks
  a_zero_ws_single: assert property (@(posedge clk) disable iff (!rst_n)
    rd_accept && ws == 2'h0 |=> fbus_ready) else $error("zero wait read not single cycle");
  a_fetch_hit_fast: assert property (@(posedge clk) disable iff (!rst_n)
    rd_accept && (hit0 || hit1) |=> fbus_ready) else $error("prefetch hit was slow");
  a_one_ws_seq: assert property (@(posedge clk) disable iff (!rst_n)
    rd_accept && seq_run && ws == 2'h1 |=> fbus_ready) else $error("sequential fetch stalled");
  sequence slow3_s;
    !fbus_ready ##1 !fbus_ready ##1 fbus_ready;
  endsequence
  a_data_no_buf: assert property (@(posedge clk) disable iff (!rst_n)
    rd_accept && !fbus.fetch && ws == 2'h2 |=> slow3_s) else $error("data read timing wrong");
  a_write_ws_cap: assert property (@(posedge clk) disable iff (!rst_n)
    wr_accept && ws == WS_MAX |=> !fbus_ready [*3] ##1 fbus_ready)
    else $error("latch write timing wrong at top setting");
  a_bad_key_err: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_wr && !key_ok |=> flags.command_error_flag && st == ST_IDLE) else $error("bad key");
  a_nocmd_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_wr && key_ok && cmd_code == CMD_NONE && !flags.command_error_flag
    |=> !flags.command_error_flag) else $error("no-op command raised error");
  a_locked_refused: assert property (@(posedge clk) disable iff (!rst_n)
    lock_viol |=> flags.region_locked_violation && st == ST_IDLE) else $error("lock ignored");
  a_prog_done_set: assert property (@(posedge clk) disable iff (!rst_n)
    phase_done && st == ST_PAGE_PROG |=> flags.program_done) else $error("program_done lost");
  a_wpl_then_lock: assert property (@(posedge clk) disable iff (!rst_n)
    phase_done && st == ST_PAGE_PROG && op_wpl |=> st == ST_LOCK_OP) else $error("no lock");
  a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
    stat_rd && !flag_set.program_done |=> !flags.program_done) else $error("flag kept");
  a_irq_or_flags: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(flags & mode.irq_en)) else $error("interrupt does not match flags");
  a_busy_no_access: assert property (@(posedge clk) disable iff (!rst_n)
    st == ST_LOCK_OP |-> !accept) else $error("access during lock operation");

endmodule
`default_nettype wire

// File: embedded_flash_controller_tb_top.sv
// Purpose: Register, command and flash access checks
// Assumes: 64 pages, 4 lock regions, short program and full erase times
// Notes:   Latency counted in edges from request to ready, i.e. L+1
`timescale 1ns/100ps
`default_nettype none
module embedded_flash_controller_tb_top;
  import flash_ctrl_pkg::*;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr_, bv, arr, rv;
  logic irq, frdy;
  logic [7:0] awa = 0, ara = 0;
  logic [3:0] wsb = 4'hf;
  logic [31:0] wd = 0, rd_, frd, q;
  logic [1:0] bresp, rresp;
  fbus_req_t fb;
  int err_total = 0, num_checks = 0, n, i;
  embedded_flash_controller #(.PAGES(64), .LOCK_REGIONS(4),
    .PAGE_PROG_US(1), .FULL_ERASE_US(1)) dut (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(wsb), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .fbus(fb), .fbus_ready(frdy), .fbus_rdata(frd), .irq(irq));
  fbus_master m (.clk(clk), .ready(frdy), .fbus(fb));
  initial forever #5 clk = ~clk;
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1; k = 0;
    do begin
      @(posedge clk);
      k++;
      if (awr) awv <= 0;
      if (wr_) wv <= 0;
    end while (bv !== 1'b1 && k < 50);
    br <= 0;
    if (k >= 50) chk(0, 1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge clk);
    ara <= a; arv <= 1; rr <= 1; k = 0;
    do begin
      @(posedge clk);
      k++;
      if (arr) arv <= 0;
    end while (rv !== 1'b1 && k < 50);
    d = rd_;
    rr <= 0;
    if (k >= 50) chk(0, 1);
  endtask
  task automatic cmd(input logic [7:0] k, input logic [5:0] p, input logic [3:0] c);
    wr(CMD_OFS, {k, 10'h0, p, 4'h0, c});
    repeat (4) @(posedge clk);
  endtask
  task automatic st(input logic [31:0] e);
    rd(STAT_OFS, q);
    chk(q, e);
  endtask
  task automatic wi;
    int k;
    for (k = 0; k < 5000 && irq !== 1'b1; k++) @(posedge clk);
    chk(irq, 1);
  endtask
  task automatic md(input logic [1:0] ws, input logic [3:0] en);
    wr(MODE_OFS, 32'h0001_0000 | {22'h0, ws, 8'h0} | {28'h0, en});
  endtask
  task automatic fr(input logic f, input logic [31:0] a, input int l, input logic [31:0] e);
    m.acc(0, f, 2'h0, a, 0, n);
    chk(n, l);
    chk(frd, e);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    rd(MODE_OFS, q); chk(q, 0);
    md(0, 0); rd(MODE_OFS, q); chk(q, 32'h0001_0000);
    rd(8'h6c, q); chk(rresp, RESP_SLVERR);
    cmd(8'h5a, 0, 1); chk(irq, 0); st(32'h8); st(0);
    cmd(8'ha5, 0, 5); st(32'h8); cmd(8'ha5, 0, 0); st(0);
    md(0, 4'he); cmd(8'ha5, 0, 9); chk(irq, 1); st(32'h8); chk(irq, 0);
    cmd(8'ha5, 40, 2); wi; st(32'h4000_0002);
    cmd(8'ha5, 41, 1); wi; st(32'h4000_0004); chk(irq, 0);
    cmd(8'ha5, 0, 8); wi; st(32'h4000_0004);
    cmd(8'ha5, 47, 4); wi; st(32'h2);
    md(0, 1); m.acc(1, 0, 2'h2, 32'h3000, 32'h1234_0000, n); chk(n, 3);
    md(3, 1);
    for (i = 1; i < 64; i++) begin
      m.acc(1, 0, 2'h2, 32'h3000 + 4 * i, 32'h1234_0000 + i, n);
      chk(n, 5);
    end
    cmd(8'ha5, 5, 1); wi; st(32'h1); repeat (3) @(posedge clk); chk(irq, 0);
    md(2, 0);
    fr(0, 32'h500, 4, 32'h1234_0000);
    fr(1, 32'h504, 4, 32'h1234_0001);
    fr(1, 32'h508, 2, 32'h1234_0002);
    fr(0, 32'h50c, 4, 32'h1234_0003);
    fr(0, 32'h4504, 4, 32'h1234_0001);
    md(1, 0);
    fr(1, 32'h510, 3, 32'h1234_0004);
    fr(1, 32'h514, 2, 32'h1234_0005);
    fr(1, 32'h518, 2, 32'h1234_0006);
    md(0, 0); fr(0, 32'h51c, 2, 32'h1234_0007);
    wsb <= 4'h1; wr(MODE_OFS, 32'hffff_ff81); wsb <= 4'hf;
    rd(MODE_OFS, q); chk(q, 32'h0001_0081);
    wsb <= 4'h7; cmd(8'h5a, 0, 1); wsb <= 4'hf; st(0);
    m.acc(1, 0, 2'h2, 32'h3000, 32'h0000_ffff, n); chk(n, 3);
    cmd(8'ha5, 5, 1); wi; st(32'h1); fr(0, 32'h500, 2, 32'h0);
    md(0, 4'h2); cmd(8'ha5, 6, 3); wi; st(32'h1000_0003);
    fr(0, 32'h604, 2, 32'h1234_0001);
    cmd(8'ha5, 6, 4); wi; st(32'h2);
    md(0, 4'h1); cmd(8'ha5, 0, 8); wi; st(32'h1); fr(0, 32'h500, 2, 32'hffff_ffff);
    close_out;
  end
endmodule
`default_nettype wire

// File: fbus_master.sv
// Purpose: Bus master model on the flash side of the controller
// Assumes: One access at a time, held until fbus_ready
// Notes:   Released address and data lines show inverted values, not the last ones
`timescale 1ns/100ps
`default_nettype none
module fbus_master
  import flash_ctrl_pkg::*;
(
  // Clock and handshake
  input  wire logic clk,
  input  wire logic ready,
  // Request
  output fbus_req_t fbus
);
  initial fbus = '0;
  // Word writes only, so the latch never sees partial lanes
  task automatic acc(input logic w, f, input logic [1:0] sz,
                     input logic [31:0] a, d, output int n);
    @(posedge clk);
    fbus <= '{1'b1, w, f, sz, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 200);
    fbus <= '{1'b0, w, f, sz, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// File: flash_ctrl_pkg.sv
// Purpose: Shared constants and types for the embedded flash controller
// Assumes: 32-bit register data, byte addressed register map
// Notes:   Command codes, field positions and register offsets live here
package flash_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0]  MODE_OFS    = 8'h60;
  localparam logic [7:0]  CMD_OFS     = 8'h64;
  localparam logic [7:0]  STAT_OFS    = 8'h68;
  localparam int          REG_AW      = 8;

  // Mode register fields
  localparam int          CYCLES_PER_MICROSECOND_LSB    = 16;
  localparam int          FWS_LSB     = 8;
  localparam int          SKIP_PAGE_ERASE_BIT    = 7;
  localparam int          IRQ_EN_LSB  = 0;

  // Command register fields
  localparam int          KEY_LSB     = 24;
  localparam int          PAGE_LSB    = 8;
  localparam int          CODE_LSB    = 0;

  // Wait states and data constants
  localparam logic [1:0]  WS_MAX      = 2'h3;
  localparam logic [2:0]  WR_LAT_MAX  = 3'h4;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CMD_NONE           = 4'h0,
    CMD_PAGE_WRITE     = 4'h1,
    CMD_LOCK_BIT_SET   = 4'h2,
    CMD_WRITE_THEN_LOCK = 4'h3,
    CMD_LOCK_BIT_CLEAR = 4'h4,
    CMD_FULL_ERASE     = 4'h8
  } command_code_t;

  typedef enum logic [4:0] {
    ST_IDLE        = 5'h01,
    ST_PAGE_ERASE  = 5'h02,
    ST_PAGE_PROG   = 5'h04,
    ST_LOCK_OP     = 5'h08,
    ST_FULL_ERASE  = 5'h10
  } seq_state_t;

  // Status flags, bit 3 first
  typedef struct packed {
    logic command_error_flag;
    logic region_locked_violation;
    logic lock_op_done;
    logic program_done;
  } flags_t;

  typedef struct packed {
    logic [7:0] cycles_per_microsecond;
    logic [1:0] wait_state_count;
    logic       skip_page_erase;
    flags_t     irq_en;
  } mode_t;

  // Internal system bus request toward the flash region
  typedef struct packed {
    logic        req;
    logic        write;
    logic        fetch;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fbus_req_t;

endpackage
